//--- hdl/adc_ctrl_pkg.sv
`default_nettype none

package adc_ctrl_pkg;

  // ===========================================================
  // Register addresses on the local bus
  localparam logic [2:0] ADDR_INPUT_SELECT = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_A = 3'h1;
  localparam logic [2:0] ADDR_CONTROL_B = 3'h2;
  localparam logic [2:0] ADDR_RESULT_LOW = 3'h3;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h4;

  // ===========================================================
  // Input select register fields
  localparam int REF_HI = 7;
  localparam int REF_LO = 6;
  localparam int JUSTIFY_BIT = 5;
  localparam int CHAN_HI = 3;
  localparam int CHAN_LO = 0;
  localparam logic [7:0] INPUT_SELECT_MASK = 8'hEF;

  // ===========================================================
  // Control/status A fields and control B trigger source fields
  localparam int ENABLE_BIT = 7;
  localparam int START_BIT = 6;
  localparam int AUTO_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int PRESCALE_HI = 2;
  localparam int PRESCALE_LO = 0;
  localparam int TRIG_HI = 2;
  localparam int TRIG_LO = 0;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  // ===========================================================
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] FIRST_CONV_CYCLES = 5'h19;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'h0D;

  // Prescaler terminal counts, one per division factor
  localparam logic [6:0] DIV2_LIMIT = 7'h01;
  localparam logic [6:0] DIV4_LIMIT = 7'h03;
  localparam logic [6:0] DIV8_LIMIT = 7'h07;
  localparam logic [6:0] DIV16_LIMIT = 7'h0F;
  localparam logic [6:0] DIV32_LIMIT = 7'h1F;
  localparam logic [6:0] DIV64_LIMIT = 7'h3F;
  localparam logic [6:0] DIV128_LIMIT = 7'h7F;

  // Converter sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_WAIT_EDGE,
    CONV_RUN
  } conv_state_t;

endpackage : adc_ctrl_pkg

`default_nettype wire

//--- hdl/adc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

// Divides the system clock to the converter clock rate
module adc_prescaler (
  input wire logic clk, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic run, // Count while high, held cleared otherwise
  input wire logic restart, // Clear the count this cycle
  input wire logic [2:0] select, // Division code
  output logic tick // One-cycle pulse per converter clock
);

  logic [6:0] count_reg;
  logic [6:0] limit;

  // ===========================================================
  // Division limit: codes 0 and 1 both divide by two
  always_comb begin
    unique case (select)
      3'h0, 3'h1: limit = adc_ctrl_pkg::DIV2_LIMIT;
      3'h2: limit = adc_ctrl_pkg::DIV4_LIMIT;
      3'h3: limit = adc_ctrl_pkg::DIV8_LIMIT;
      3'h4: limit = adc_ctrl_pkg::DIV16_LIMIT;
      3'h5: limit = adc_ctrl_pkg::DIV32_LIMIT;
      3'h6: limit = adc_ctrl_pkg::DIV64_LIMIT;
      3'h7: limit = adc_ctrl_pkg::DIV128_LIMIT;
    endcase
  end

  // Free-running counter, cleared while disabled or on restart
  always_ff @(posedge clk) begin
    if (!resetn || !run || restart) begin
      count_reg <= 7'h00;
    end else if (count_reg >= limit) begin
      count_reg <= 7'h00;
    end else begin
      count_reg <= count_reg + 7'h01;
    end
  end

  assign tick = run && !restart && (count_reg >= limit);

endmodule : adc_prescaler

`default_nettype wire

//--- hdl/adc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - Result is 10-bit code vin*1024/vref, zero ground, 0x3FF top step.
// R2 - Reference field picks pin, supply, reserved, internal; latched per conversion.
// R3 - Justify bit left or right aligns result immediately, even mid-conversion.
// R4 - Bit 4 of input select ignores writes and reads zero.
// R5 - Channel field selects inputs, bandgap, ground; latched per conversion.
// R6 - Enable one powers converter; zero powers off and aborts conversion.
// R7 - Start bit launches single conversions; free running starts only first.
// R8 - First conversion after enabling takes 25 cycles, later ones 13.
// R9 - Start reads one while converting, zero after; writing zero ignored.
// R10 - Auto trigger starts a conversion on each rising trigger edge.
// R11 - Done flag sets when conversion finishes and result is updated.
// R12 - Interrupt requested only when flag, enable and global enable set.
// R13 - Done flag clears when processor takes the interrupt vector.
// R14 - Writing one clears done flag; writing zero leaves it.
// R15 - Prescaler divides system clock by 2,2,4,8,16,32,64,128.
// R16 - Trigger source field selects free running or one of seven events.
// R17 - Reading low result byte blocks updates until high byte read.
// R18 - Interrupt enable bit 3 gates request with global enable.
// R19 - Analog core is a port taking channel, reference, returning 10 bits.
// R20 - Start clears and flag sets in the cycle the result is written.
module adc_conversion_control (
  input wire logic clk, // System clock, 125 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [2:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic global_irq_enable, // Processor global interrupt enable
  input wire logic irq_vector_taken, // Processor executes the vector
  output logic conversion_irq, // Interrupt request
  input wire logic [6:0] trigger_events, // Trigger sources 1 to 7
  output logic analog_power, // Converter powered
  output logic [3:0] analog_channel, // Channel for the analog core
  output logic [1:0] analog_reference, // Reference for the analog core
  output logic analog_sample, // Pulse: conversion starts
  input wire logic [9:0] analog_value // Core result at conversion end
);

  logic [7:0] input_select_reg;
  logic [7:0] control_status_a_reg;
  logic enable_reg, start_reg, auto_reg, done_reg, irq_en_reg;
  logic [2:0] prescale_select;
  logic [2:0] trigger_source_select;
  logic [3:0] locked_channel_reg;
  logic [1:0] locked_reference_reg;
  logic [9:0] result_reg;
  logic result_block_reg;
  logic first_pending_reg;
  logic first_conv_reg;
  logic [4:0] cycle_count_reg;
  logic [2:0] trig_sync_reg;
  logic trig_prev_reg;
  adc_ctrl_pkg::conv_state_t state_reg;
  logic tick;
  logic enable;
  logic auto_on;
  logic free_run;
  logic trig_level;
  logic trig_rise;
  logic wr_sel;
  logic wr_ctl;
  logic start_write;
  logic conv_end;
  logic [4:0] conv_len;
  logic [15:0] presented;

  // ===========================================================
  // Decode
  assign wr_sel = reg_write && (reg_addr == adc_ctrl_pkg::ADDR_INPUT_SELECT);
  assign wr_ctl = reg_write && (reg_addr == adc_ctrl_pkg::ADDR_CONTROL_A);
  assign control_status_a_reg = {enable_reg, start_reg, auto_reg, done_reg,
      irq_en_reg, prescale_select};
  assign enable = control_status_a_reg[adc_ctrl_pkg::ENABLE_BIT];
  assign auto_on = control_status_a_reg[adc_ctrl_pkg::AUTO_BIT];
  assign free_run = auto_on &&
      (trigger_source_select == adc_ctrl_pkg::TRIG_FREE_RUN);
  assign start_write = wr_ctl && reg_wdata[adc_ctrl_pkg::START_BIT]
      && reg_wdata[adc_ctrl_pkg::ENABLE_BIT];
  assign conv_len = first_conv_reg ? adc_ctrl_pkg::FIRST_CONV_CYCLES
      : adc_ctrl_pkg::NORMAL_CONV_CYCLES;
  assign conv_end = (state_reg == adc_ctrl_pkg::CONV_RUN) && tick
      && (cycle_count_reg == conv_len - 5'h01);

  // ===========================================================
  // Trigger path: three-stage synchroniser, second/third agree
  // R16 source select
  always_comb begin
    if (trigger_source_select == adc_ctrl_pkg::TRIG_FREE_RUN) begin
      trig_level = 1'b0;
    end else begin
      trig_level = trigger_events[trigger_source_select - 3'h1];
    end
  end

  // Synchroniser for the selected event level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig_sync_reg <= 3'h0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], trig_level};
    end
  end

  // Settled level tracker
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig_prev_reg <= 1'b0;
    end else if (trig_sync_reg[1] == trig_sync_reg[2]) begin
      trig_prev_reg <= trig_sync_reg[2];
    end
  end

  // R10 rising edge
  assign trig_rise = auto_on && enable && !free_run
      && trig_sync_reg[1] && trig_sync_reg[2] && !trig_prev_reg;

  // ===========================================================
  // R15 prescaler, reset on trigger
  adc_prescaler prescaler_inst (
    .clk(clk),
    .resetn(resetn),
    .run(enable),
    .restart(trig_rise),
    .select(prescale_select),
    .tick(tick)
  );

  // ===========================================================
  // Input select register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      input_select_reg <= adc_ctrl_pkg::RESET_VALUE;
    end else if (wr_sel) begin
      // R4 bit four discarded
      input_select_reg <= reg_wdata & adc_ctrl_pkg::INPUT_SELECT_MASK;
    end
  end

  // Trigger source register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trigger_source_select <= 3'h0;
    end else if (reg_write && (reg_addr == adc_ctrl_pkg::ADDR_CONTROL_B)) begin
      trigger_source_select <=
          reg_wdata[adc_ctrl_pkg::TRIG_HI:adc_ctrl_pkg::TRIG_LO];
    end
  end

  // R2 R5 selection tracks until conversion runs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      locked_channel_reg <= 4'h0;
      locked_reference_reg <= 2'h0;
    end else if (state_reg != adc_ctrl_pkg::CONV_RUN || conv_end) begin
      locked_channel_reg <=
          input_select_reg[adc_ctrl_pkg::CHAN_HI:adc_ctrl_pkg::CHAN_LO];
      locked_reference_reg <=
          input_select_reg[adc_ctrl_pkg::REF_HI:adc_ctrl_pkg::REF_LO];
    end
  end

  // ===========================================================
  // Control/status A plain fields
  always_ff @(posedge clk) begin
    if (!resetn) begin
      enable_reg <= 1'b0;
      auto_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      prescale_select <= 3'h0;
    end else if (wr_ctl) begin
      // R6 enable bit
      enable_reg <= reg_wdata[adc_ctrl_pkg::ENABLE_BIT];
      auto_reg <= reg_wdata[adc_ctrl_pkg::AUTO_BIT];
      irq_en_reg <= reg_wdata[adc_ctrl_pkg::IRQ_EN_BIT];
      prescale_select <=
          reg_wdata[adc_ctrl_pkg::PRESCALE_HI:adc_ctrl_pkg::PRESCALE_LO];
    end
  end

  // R9 start bit: set by write of one, cleared at end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_reg <= 1'b0;
    end else if (wr_ctl && !reg_wdata[adc_ctrl_pkg::ENABLE_BIT]) begin
      // R6 abort clears start
      start_reg <= 1'b0;
    end else if (start_write || trig_rise) begin
      // R7 launch
      start_reg <= 1'b1;
    end else if (conv_end && !free_run) begin
      // R20 clears with result write
      start_reg <= 1'b0;
    end
  end

  // R11 done flag, set wins over clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else if (conv_end && !result_block_reg) begin
      // R20 set with result write
      done_reg <= 1'b1;
    end else if (irq_vector_taken ||
        (wr_ctl && reg_wdata[adc_ctrl_pkg::DONE_BIT])) begin
      // R13 R14 clear on vector or written one
      done_reg <= 1'b0;
    end
  end

  // ===========================================================
  // R8 first conversion after enable is long
  always_ff @(posedge clk) begin
    if (!resetn) begin
      first_pending_reg <= 1'b0;
    end else if (!enable) begin
      first_pending_reg <= 1'b1;
    end else if (state_reg == adc_ctrl_pkg::CONV_WAIT_EDGE && tick) begin
      first_pending_reg <= 1'b0;
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= adc_ctrl_pkg::CONV_IDLE;
      cycle_count_reg <= 5'h00;
      first_conv_reg <= 1'b0;
    end else if (!enable) begin
      // R6 abort
      state_reg <= adc_ctrl_pkg::CONV_IDLE;
      cycle_count_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        adc_ctrl_pkg::CONV_IDLE: begin
          if (control_status_a_reg[adc_ctrl_pkg::START_BIT]) begin
            state_reg <= adc_ctrl_pkg::CONV_WAIT_EDGE;
          end
        end
        adc_ctrl_pkg::CONV_WAIT_EDGE: begin
          if (tick) begin
            state_reg <= adc_ctrl_pkg::CONV_RUN;
            cycle_count_reg <= 5'h00;
            first_conv_reg <= first_pending_reg;
          end
        end
        adc_ctrl_pkg::CONV_RUN: begin
          if (conv_end) begin
            cycle_count_reg <= 5'h00;
            // R7 free running restarts at once
            if (free_run) begin
              first_conv_reg <= 1'b0;
            end else begin
              state_reg <= adc_ctrl_pkg::CONV_IDLE;
            end
          end else if (tick) begin
            cycle_count_reg <= cycle_count_reg + 5'h01;
          end
        end
      endcase
    end
  end

  // ===========================================================
  // R19 R1 result capture; R17 block after low byte read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_reg <= 10'h000;
    end else if (conv_end && !result_block_reg) begin
      result_reg <= analog_value;
    end
  end

  // R17 low read locks, high read releases
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_block_reg <= 1'b0;
    end else if (reg_read && reg_addr == adc_ctrl_pkg::ADDR_RESULT_LOW) begin
      result_block_reg <= 1'b1;
    end else if (reg_read && reg_addr == adc_ctrl_pkg::ADDR_RESULT_HIGH) begin
      result_block_reg <= 1'b0;
    end
  end

  // R3 justification applied at read time
  assign presented = input_select_reg[adc_ctrl_pkg::JUSTIFY_BIT]
      ? {result_reg, 6'h00} : {6'h00, result_reg};

  // Read data, one cycle after strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        adc_ctrl_pkg::ADDR_INPUT_SELECT: reg_rdata <= input_select_reg;
        adc_ctrl_pkg::ADDR_CONTROL_A: reg_rdata <= control_status_a_reg;
        adc_ctrl_pkg::ADDR_CONTROL_B: reg_rdata <= {5'h00,
            trigger_source_select};
        adc_ctrl_pkg::ADDR_RESULT_LOW: reg_rdata <= presented[7:0];
        adc_ctrl_pkg::ADDR_RESULT_HIGH: reg_rdata <= presented[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ===========================================================
  // R12 R18 interrupt request
  assign conversion_irq = control_status_a_reg[adc_ctrl_pkg::DONE_BIT]
      && control_status_a_reg[adc_ctrl_pkg::IRQ_EN_BIT] && global_irq_enable;

  // Analog core drive
  assign analog_power = enable;
  assign analog_channel = locked_channel_reg;
  assign analog_reference = locked_reference_reg;
  // Free running: next conversion starts as the last one ends
  assign analog_sample = ((state_reg == adc_ctrl_pkg::CONV_WAIT_EDGE) && tick)
      || (conv_end && free_run);

endmodule : adc_conversion_control

`default_nettype wire

//--- tb/adc_conversion_control_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checker for the conversion control block
module adc_conversion_control_chk (
  input wire logic clk, // System clock
  input wire logic resetn, // Sync reset, active low
  input wire logic [2:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic global_irq_enable, // Global enable
  input wire logic irq_vector_taken, // Vector taken
  input wire logic conversion_irq, // Interrupt request
  input wire logic analog_power, // Converter powered
  input wire logic [3:0] analog_channel, // Locked channel
  input wire logic [1:0] analog_reference, // Locked reference
  input wire logic analog_sample // Conversion start pulse
);
  logic rd_ctl;
  logic wr_ctl;

  // Control register access decode
  assign rd_ctl = reg_read && reg_addr == adc_ctrl_pkg::ADDR_CONTROL_A;
  assign wr_ctl = reg_write && reg_addr == adc_ctrl_pkg::ADDR_CONTROL_A;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Assertions
  AST_IRQ_GATE: assert property (conversion_irq |-> global_irq_enable)
    else $error("irq without global enable");
  AST_IRQ_FLAG: assert property (rd_ctl |=> $past(conversion_irq) ==
    (reg_rdata[4] && reg_rdata[3] && $past(global_irq_enable)))
    else $error("irq not flag and enables");
  AST_READ_POWER: assert property (rd_ctl |=>
    reg_rdata[7] == $past(analog_power))
    else $error("enable bit differs from power");
  AST_SEL_BIT4: assert property (reg_read &&
    reg_addr == adc_ctrl_pkg::ADDR_INPUT_SELECT |=> !reg_rdata[4])
    else $error("unused select bit reads one");
  AST_OFF_ABORT: assert property (wr_ctl && !reg_wdata[7] |=>
    !analog_power && !analog_sample)
    else $error("disable did not power off");
  AST_START_LAUNCH: assert property (wr_ctl && reg_wdata[7] &&
    reg_wdata[6] |-> ##[1:300] analog_sample)
    else $error("start did not launch");
  AST_CHAN_LOCK: assert property (analog_sample |=>
    $stable(analog_channel) [*8])
    else $error("channel moved mid conversion");
  AST_REF_LOCK: assert property (analog_sample |=>
    $stable(analog_reference) [*8])
    else $error("reference moved mid conversion");
  AST_VEC_CLEAR: assert property (irq_vector_taken |=>
    !conversion_irq)
    else $error("vector did not clear flag");
  AST_W1C: assert property (wr_ctl && reg_wdata[4] |=>
    !conversion_irq)
    else $error("write one did not clear flag");

  // Main scenario coverage
  COV_SAMPLE: cover property (analog_sample);
  COV_DONE: cover property ($rose(conversion_irq));
  COV_FREE: cover property (analog_sample ##[20:40] analog_sample);
endmodule : adc_conversion_control_chk

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the conversion control block
module tb;
  localparam logic [2:0] SEL = adc_ctrl_pkg::ADDR_INPUT_SELECT;
  localparam logic [2:0] CTL = adc_ctrl_pkg::ADDR_CONTROL_A;
  localparam logic [2:0] TRG = adc_ctrl_pkg::ADDR_CONTROL_B;
  localparam logic [2:0] RLO = adc_ctrl_pkg::ADDR_RESULT_LOW;
  localparam logic [2:0] RHI = adc_ctrl_pkg::ADDR_RESULT_HIGH;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic global_irq_enable = 1'b1;
  logic irq_vector_taken = 1'b0;
  logic [6:0] trigger_events = 7'h00;
  logic [9:0] analog_value = 10'h000;
  logic [7:0] reg_rdata;
  logic conversion_irq;
  logic analog_power;
  logic [3:0] analog_channel;
  logic [1:0] analog_reference;
  logic analog_sample;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int t0, d, d1, d2, d3, dv;

  adc_conversion_control i_dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .conversion_irq(conversion_irq),
    .trigger_events(trigger_events), .analog_power(analog_power),
    .analog_channel(analog_channel), .analog_reference(analog_reference),
    .analog_sample(analog_sample), .analog_value(analog_value)
  );

  // Clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end

  // Cycle count and hang limit
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      final_report();
    end
  end

  // ==========================================================
  // Tasks
  task final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  // Wait for a conversion start and note its cycle
  task launch;
    int n;
    n = 0;
    #1;
    while (analog_sample !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
    chk(analog_sample, 1'b1);
    t0 = cycles;
  endtask : launch

  // Wait for the done request and return the length
  task fin(output int dd);
    int n;
    n = 0;
    while (conversion_irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(conversion_irq, 1'b1);
    dd = cycles - t0;
  endtask : fin

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(SEL, 8'h00);
    rd(CTL, 8'h00);
    rd(3'h5, 8'h00);
    wr(SEL, 8'hFF);
    rd(SEL, 8'hEF);
    wr(SEL, 8'h05);
    analog_value <= 10'h2A5;
    wr(CTL, 8'hC8);
    launch();
    fin(d1);
    chk(16'(d1), 16'h33);
    rd(CTL, 8'h98);
    rd(RLO, 8'hA5);
    rd(RHI, 8'h02);
    wr(SEL, 8'h25);
    rd(RLO, 8'h40);
    rd(RHI, 8'hA9);
    @(posedge clk);
    global_irq_enable <= 1'b0;
    @(posedge clk);
    #1 chk(conversion_irq, 1'b0);
    @(posedge clk);
    global_irq_enable <= 1'b1;
    wr(CTL, 8'h80);
    #1 chk(conversion_irq, 1'b0);
    wr(CTL, 8'h88);
    rd(CTL, 8'h98);
    wr(CTL, 8'h98);
    rd(CTL, 8'h88);
    // Selection held while converting, start ignores zero
    wr(SEL, 8'h05);
    analog_value <= 10'h155;
    wr(CTL, 8'hC8);
    launch();
    wr(SEL, 8'hCF);
    wr(CTL, 8'h88);
    rd(CTL, 8'hC8);
    chk(analog_channel, 16'h5);
    chk(analog_reference, 16'h0);
    fin(d2);
    chk(16'(d2), 16'h1B);
    chk(16'(d1 - d2), 16'h18);
    chk(analog_channel, 16'hF);
    chk(analog_reference, 16'h3);
    rd(RLO, 8'h55);
    rd(RHI, 8'h01);
    @(posedge clk);
    irq_vector_taken <= 1'b1;
    @(posedge clk);
    irq_vector_taken <= 1'b0;
    #1 chk(conversion_irq, 1'b0);
    // Low byte read holds the result
    rd(RLO, 8'h55);
    @(posedge clk);
    analog_value <= 10'h0F0;
    wr(CTL, 8'hC8);
    launch();
    repeat (60) @(posedge clk);
    #1 chk(conversion_irq, 1'b0);
    rd(RHI, 8'h01);
    // Abort, then a fresh first conversion
    wr(CTL, 8'hC8);
    launch();
    repeat (6) @(posedge clk);
    wr(CTL, 8'h08);
    rd(CTL, 8'h08);
    repeat (60) @(posedge clk);
    #1 chk(conversion_irq, 1'b0);
    wr(CTL, 8'hC8);
    launch();
    fin(d3);
    chk(16'(d3), 16'(d1));
    wr(CTL, 8'h98);
    // Every prescale code
    for (int c = 0; c < 8; c++) begin
      dv = (c == 0) ? 2 : (1 << c);
      wr(CTL, 8'hC8 | 8'(c));
      launch();
      fin(d);
      chk(16'(d), 16'(adc_ctrl_pkg::NORMAL_CONV_CYCLES * dv + 1));
      wr(CTL, 8'h98 | 8'(c));
    end
    // Every trigger source
    wr(CTL, 8'hB8);
    for (int t = 1; t < 8; t++) begin
      wr(TRG, 8'(t));
      @(posedge clk);
      trigger_events <= 7'h01 << (t - 1);
      launch();
      fin(d);
      chk(16'(d), 16'h1B);
      wr(CTL, 8'hB8);
      trigger_events <= 7'h00;
    end
    // Free running keeps converting
    wr(TRG, 8'h00);
    wr(CTL, 8'hE8);
    launch();
    fin(d);
    chk(16'(d), 16'h1B);
    launch();
    rd(CTL, 8'hF8);
    wr(CTL, 8'h00);
    final_report();
  end
endmodule : tb

bind adc_conversion_control adc_conversion_control_chk i_chk (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
  .irq_vector_taken(irq_vector_taken), .conversion_irq(conversion_irq),
  .analog_power(analog_power), .analog_channel(analog_channel),
  .analog_reference(analog_reference), .analog_sample(analog_sample)
);

`default_nettype wire
